// ==== rtl/sleep_and_leakage_regulator_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

// Function
// - every wake-up from deep sleep with the enable bit set starts a fresh calibration cycle
// - deep sleep keeps power chain on until first calibration cycle completes or written data commits
// - calibration starts 4 oscillator ticks after deep wake; earlier sleep keeps old data
// - after enable clears, control and data registers settle within five slow ticks
// - calibration starts after power-up when enable bit is set, its reset value
// - done bit sets when a calibration cycle completes
// - calibration runs continuously until deep sleep or enable clears
// - stopped regulator level comes from data registers plus coefficient and short bits
// - data writes, and control writes other than the enable bit, are taken only while enable is zero
// - a larger calibration code means a lower sleep output voltage
// - written data reaches regulator logic after at least two slow ticks
// - high byte goes first; a high write not followed by low is dropped
// - bit 0 enables calibration; bit 3 shows active or sync pending
// - sleep mode field decodes idle, noise, down, save, standby, extended standby
// - sleep instruction sleeps only with sleep enable set
// - bits 7, 2, 1 stop two-wire, serial peripheral and serial port clocks
// - bits 6, 5, 3 halt timers 2, 0, 1; clearing resumes them unchanged
// - bit 4 lowers amplifier bias without powering it off
module sleep_and_leakage_regulator_ctrl #(
  parameter int CAL_STEPS = 16
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [11:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        SLEEP_INSTR_I,
  input  wire logic        WAKE_I,
  input  wire logic        CAL_COMPARE_I,
  output logic             POWER_CHAIN_EN_O,
  output logic             SLEEP_ACTIVE_O,
  output logic             DEEP_SLEEP_O,
  output logic      [2:0]  SLEEP_MODE_O,
  output logic      [15:0] REG_TRIM_O,
  output logic             TEMP_COEFF_O,
  output logic             REG_SHORT_O,
  output logic             GATE_TWO_WIRE_O,
  output logic             GATE_TIMER_2_O,
  output logic             GATE_TIMER_0_O,
  output logic             GAIN_AMP_LOW_CURRENT_O,
  output logic             GATE_TIMER_1_O,
  output logic             GATE_SERIAL_PERIPHERAL_O,
  output logic             GATE_SERIAL_PORT_0_O
);

  localparam int STEP_W = $clog2(CAL_STEPS + 1);

  if (CAL_STEPS < 2 || CAL_STEPS > 4096) begin : g_bad_steps
    $error("CAL_STEPS out of range");
  end

  function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
    hit = (addr[9:2] == idx) && (addr[11:10] == 2'h0);
  endfunction

  function automatic logic is_deep(input logic [2:0] mode);
    is_deep = (mode == slr_pkg::MODE_PWR_DOWN) || (mode == slr_pkg::MODE_PWR_SAVE);
  endfunction

  // slow tick generation from the system clock
  logic [8:0] div_reg;
  logic       half_reg;
  logic       tick128;
  logic       tick64;

  assign tick128 = (div_reg == 9'(slr_pkg::TICK128_CYC - 1));
  assign tick64  = tick128 && half_reg;

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      div_reg  <= 9'h000;
      half_reg <= 1'b0;
    end else if (tick128) begin
      div_reg  <= 9'h000;
      half_reg <= ~half_reg;
    end else begin
      div_reg <= div_reg + 9'h001;
    end
  end

  // pin synchronisers
  logic wake_s1_reg, wake_s2_reg, cmp_s1_reg, cmp_s2_reg;

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      cmp_s1_reg  <= 1'b0;
      cmp_s2_reg  <= 1'b0;
    end else begin
      wake_s1_reg <= WAKE_I;
      wake_s2_reg <= wake_s1_reg;
      cmp_s1_reg  <= CAL_COMPARE_I;
      cmp_s2_reg  <= cmp_s1_reg;
    end
  end

  // bus slave: zero wait states, always okay
  logic       dp_wr_reg;
  logic [7:0] dp_idx_reg;
  logic       addr_ok;
  logic [7:0] wdat;

  assign addr_ok     = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign wdat        = HWDATA_I[7:0];

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dp_wr_reg  <= 1'b0;
      dp_idx_reg <= 8'h00;
    end else begin
      dp_wr_reg  <= addr_ok && HWRITE_I && (HSIZE_I == 3'h2);
      dp_idx_reg <= HADDR_I[9:2];
    end
  end

  logic wr_sleep_mode_control, wr_prr, wr_ctrl, wr_low, wr_high;
  assign wr_sleep_mode_control = dp_wr_reg && (dp_idx_reg == slr_pkg::IDX_SLEEP_MODE_CONTROL);
  assign wr_prr  = dp_wr_reg && (dp_idx_reg == slr_pkg::IDX_POWER_REDUCTION_0);
  assign wr_ctrl = dp_wr_reg && (dp_idx_reg == slr_pkg::IDX_CAL_CONTROL);
  assign wr_low  = dp_wr_reg && (dp_idx_reg == slr_pkg::IDX_CAL_DATA_LOW);
  assign wr_high = dp_wr_reg && (dp_idx_reg == slr_pkg::IDX_CAL_DATA_HIGH);

  // sleep control and power reduction
  logic [7:0] sleep_mode_control_reg, prr_reg;

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sleep_mode_control_reg <= slr_pkg::SLEEP_CTRL_RST;
    end else if (wr_sleep_mode_control) begin
      sleep_mode_control_reg <= {4'h0, wdat[slr_pkg::MODE_MSB:0]};
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prr_reg <= slr_pkg::PWR_RED_RST;
    end else if (wr_prr) begin
      prr_reg <= {wdat[7:1], 1'b0};
    end
  end

  // clock stop and halt levels; halted timers keep their state
  assign GATE_TWO_WIRE_O          = prr_reg[slr_pkg::GATE_TWO_WIRE_BIT];
  assign GATE_SERIAL_PERIPHERAL_O = prr_reg[slr_pkg::GATE_SPI_BIT];
  assign GATE_SERIAL_PORT_0_O     = prr_reg[slr_pkg::GATE_SERIAL_0_BIT];
  assign GATE_TIMER_2_O           = prr_reg[slr_pkg::GATE_TIMER_2_BIT];
  assign GATE_TIMER_0_O           = prr_reg[slr_pkg::GATE_TIMER_0_BIT];
  assign GATE_TIMER_1_O           = prr_reg[slr_pkg::GATE_TIMER_1_BIT];
  assign GAIN_AMP_LOW_CURRENT_O   = prr_reg[slr_pkg::GAIN_AMP_LOW_BIT];

  // calibration control, bus-side shadows
  logic [2:0] sh_ctrl_reg;
  logic [7:0] sh_low_reg, sh_high_reg;
  logic       hi_armed_reg, low_pend_reg, ctrl_pend_reg;
  logic [1:0] sync_cnt_reg;
  logic       pending, commit, sh_en;

  assign sh_en   = sh_ctrl_reg[slr_pkg::CAL_EN_BIT];
  assign pending = ctrl_pend_reg || low_pend_reg;
  assign commit  = pending && tick64 && (sync_cnt_reg == 2'(slr_pkg::SYNC_TICKS - 1));

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sh_ctrl_reg <= slr_pkg::CAL_CTRL_RST;
    end else if (wr_ctrl) begin
      // while enabled only the enable bit itself may change
      if (!sh_en) begin
        sh_ctrl_reg <= wdat[2:0];
      end else begin
        sh_ctrl_reg[slr_pkg::CAL_EN_BIT] <= wdat[slr_pkg::CAL_EN_BIT];
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sh_low_reg   <= slr_pkg::CAL_DATA_RST;
      sh_high_reg  <= slr_pkg::CAL_DATA_RST;
      hi_armed_reg <= 1'b0;
    end else if (wr_high && !sh_en) begin
      sh_high_reg  <= wdat;
      hi_armed_reg <= 1'b1;
    end else if (wr_low && !sh_en) begin
      sh_low_reg <= wdat;
    end else if (dp_wr_reg || commit) begin
      // any other write between high and low drops the high byte
      hi_armed_reg <= hi_armed_reg && commit && low_pend_reg ? 1'b0 :
                      (dp_wr_reg ? 1'b0 : hi_armed_reg);
    end
  end

  logic hi_take_reg;

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      low_pend_reg  <= 1'b0;
      hi_take_reg   <= 1'b0;
      ctrl_pend_reg <= 1'b0;
      sync_cnt_reg  <= 2'h0;
    end else if ((wr_low && !sh_en) || wr_ctrl) begin
      // a new low-byte or control write restarts the crossing
      low_pend_reg  <= low_pend_reg || (wr_low && !sh_en);
      hi_take_reg   <= hi_take_reg || (wr_low && hi_armed_reg);
      ctrl_pend_reg <= ctrl_pend_reg || wr_ctrl;
      sync_cnt_reg  <= 2'h0;
    end else if (commit) begin
      low_pend_reg  <= 1'b0;
      hi_take_reg   <= 1'b0;
      ctrl_pend_reg <= 1'b0;
      sync_cnt_reg  <= 2'h0;
    end else if (pending && tick64) begin
      sync_cnt_reg <= sync_cnt_reg + 2'h1;
    end
  end

  // power state machine
  slr_pkg::pm_state_t state_reg, state_next;
  logic [2:0] wake_cnt_reg;
  logic       cal_valid_reg;
  logic       sleep_req;
  logic       wake_done;

  assign sleep_req = SLEEP_INSTR_I && sleep_mode_control_reg[slr_pkg::SE_BIT];
  assign wake_done = tick128 && (wake_cnt_reg == 3'(slr_pkg::WAKE_OSC_TICKS - 1));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      slr_pkg::ST_AWAKE: begin
        if (sleep_req) begin
          // reserved codes 4 and 5 leave the core running
          if (is_deep(sleep_mode_control_reg[slr_pkg::MODE_MSB:slr_pkg::MODE_LSB])) begin
            state_next = cal_valid_reg ? slr_pkg::ST_DEEP : slr_pkg::ST_HOLD;
          end else if (sleep_mode_control_reg[slr_pkg::MODE_MSB:slr_pkg::MODE_LSB] != slr_pkg::MODE_RES_4 &&
                       sleep_mode_control_reg[slr_pkg::MODE_MSB:slr_pkg::MODE_LSB] != slr_pkg::MODE_RES_5) begin
            state_next = slr_pkg::ST_LIGHT;
          end
        end
      end
      slr_pkg::ST_LIGHT: begin
        if (wake_s2_reg) begin
          state_next = slr_pkg::ST_AWAKE;
        end
      end
      slr_pkg::ST_HOLD: begin
        if (wake_s2_reg) begin
          state_next = slr_pkg::ST_AWAKE;
        end else if (cal_valid_reg) begin
          state_next = slr_pkg::ST_DEEP;
        end
      end
      slr_pkg::ST_DEEP: begin
        if (wake_s2_reg) begin
          state_next = slr_pkg::ST_WAKEUP;
        end
      end
      slr_pkg::ST_WAKEUP: begin
        if (sleep_req) begin
          state_next = slr_pkg::ST_DEEP;
        end else if (wake_done) begin
          state_next = slr_pkg::ST_AWAKE;
        end
      end
      default: state_next = slr_pkg::ST_AWAKE;
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg <= slr_pkg::ST_AWAKE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wake_cnt_reg <= 3'h0;
    end else if (state_reg != slr_pkg::ST_WAKEUP) begin
      wake_cnt_reg <= 3'h0;
    end else if (tick128) begin
      wake_cnt_reg <= wake_cnt_reg + 3'h1;
    end
  end

  // regulator-side calibration engine, stepping on slow ticks
  logic [2:0]        eff_ctrl_reg;
  logic [7:0]        eff_low_reg, eff_high_reg;
  logic              cal_run_reg, cal_done_reg;
  logic [STEP_W-1:0] step_reg;
  logic              wake_start, cal_end;
  logic [15:0]       code;

  assign wake_start = (state_reg == slr_pkg::ST_WAKEUP) && (state_next == slr_pkg::ST_AWAKE);
  assign cal_end    = cal_run_reg && tick64 && (step_reg == STEP_W'(CAL_STEPS - 1));
  assign code       = {eff_high_reg, eff_low_reg};

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      eff_ctrl_reg <= slr_pkg::CAL_CTRL_RST;
    end else if (commit && ctrl_pend_reg) begin
      eff_ctrl_reg <= sh_ctrl_reg;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cal_run_reg <= 1'b1;
      step_reg    <= '0;
    end else if ((commit && ctrl_pend_reg && !sh_ctrl_reg[slr_pkg::CAL_EN_BIT])
                 || state_reg == slr_pkg::ST_DEEP) begin
      cal_run_reg <= 1'b0;
      step_reg    <= '0;
    end else if (wake_start || (commit && ctrl_pend_reg && sh_ctrl_reg[slr_pkg::CAL_EN_BIT])) begin
      cal_run_reg <= eff_ctrl_reg[slr_pkg::CAL_EN_BIT] || sh_ctrl_reg[slr_pkg::CAL_EN_BIT];
      step_reg    <= '0;
    end else if (cal_run_reg && tick64) begin
      step_reg <= cal_end ? '0 : step_reg + STEP_W'(1);
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cal_done_reg  <= 1'b0;
      cal_valid_reg <= 1'b0;
    end else if (cal_end) begin
      cal_done_reg  <= 1'b1;
      cal_valid_reg <= 1'b1;
    end else if (wake_start && eff_ctrl_reg[slr_pkg::CAL_EN_BIT]) begin
      cal_done_reg <= 1'b0;
    end else if (commit && low_pend_reg) begin
      cal_valid_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      eff_low_reg  <= slr_pkg::CAL_DATA_RST;
      eff_high_reg <= slr_pkg::CAL_DATA_RST;
    end else if (commit && low_pend_reg) begin
      eff_low_reg <= sh_low_reg;
      if (hi_take_reg) begin
        eff_high_reg <= sh_high_reg;
      end
    end else if (cal_run_reg && tick64) begin
      // compare high means output above target: raise code to lower it
      if (cmp_s2_reg && code != 16'hffff) begin
        {eff_high_reg, eff_low_reg} <= code + 16'h0001;
      end else if (!cmp_s2_reg && code != 16'h0000) begin
        {eff_high_reg, eff_low_reg} <= code - 16'h0001;
      end
    end
  end

  assign REG_TRIM_O   = code;
  assign TEMP_COEFF_O = eff_ctrl_reg[slr_pkg::CAL_TCO_BIT];
  assign REG_SHORT_O  = eff_ctrl_reg[slr_pkg::CAL_SHORT_BIT];

  assign POWER_CHAIN_EN_O = (state_reg != slr_pkg::ST_DEEP);
  assign SLEEP_ACTIVE_O   = (state_reg != slr_pkg::ST_AWAKE);
  assign DEEP_SLEEP_O     = (state_reg == slr_pkg::ST_DEEP);
  assign SLEEP_MODE_O     = sleep_mode_control_reg[slr_pkg::MODE_MSB:slr_pkg::MODE_LSB];

  // read data registered in the address phase
  logic [7:0] ctrl_rd;
  logic [7:0] rd_val;

  always_comb begin
    ctrl_rd = {3'h0, cal_done_reg, cal_run_reg || pending, sh_ctrl_reg};
    rd_val  = 8'h00;
    if (hit(HADDR_I, slr_pkg::IDX_SLEEP_MODE_CONTROL)) rd_val = sleep_mode_control_reg;
    if (hit(HADDR_I, slr_pkg::IDX_POWER_REDUCTION_0))  rd_val = prr_reg;
    if (hit(HADDR_I, slr_pkg::IDX_CAL_CONTROL))        rd_val = ctrl_rd;
    if (hit(HADDR_I, slr_pkg::IDX_CAL_DATA_LOW))       rd_val = eff_low_reg;
    if (hit(HADDR_I, slr_pkg::IDX_CAL_DATA_HIGH))      rd_val = eff_high_reg;
    if (hit(HADDR_I, slr_pkg::IDX_PM_STATUS))          rd_val = {4'h0, cal_valid_reg, state_reg};
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      HRDATA_O <= 32'h0000_0000;
    end else if (addr_ok && !HWRITE_I) begin
      HRDATA_O <= {24'h00_0000, rd_val};
    end
  end

  hold_chain_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    !cal_valid_reg |-> POWER_CHAIN_EN_O)
    else $error("power chain dropped before first calibration");

  sleep_gate_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (state_reg == slr_pkg::ST_AWAKE && SLEEP_INSTR_I && !sleep_mode_control_reg[slr_pkg::SE_BIT])
    |=> state_reg == slr_pkg::ST_AWAKE)
    else $error("slept without sleep enable");

  wake_wait_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (state_reg == slr_pkg::ST_WAKEUP) |-> !cal_run_reg)
    else $error("calibration ran during wake delay");

  done_clear_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (wake_start && eff_ctrl_reg[slr_pkg::CAL_EN_BIT] && !cal_end) |=> !cal_done_reg && cal_run_reg)
    else $error("done not cleared at post-wake start");

  write_gate_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (wr_low && sh_en) |=> $stable(sh_low_reg))
    else $error("data write taken while enabled");

  sync_delay_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    $rose(pending) |-> !commit [*2])
    else $error("crossing committed too early");

  deep_stop_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (state_reg == slr_pkg::ST_DEEP) |=> !cal_run_reg)
    else $error("calibration running in deep sleep");

  done_set_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    cal_end |=> cal_done_reg && cal_valid_reg)
    else $error("done not set after cycle");

  hi_drop_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
    (hi_armed_reg && dp_wr_reg && !wr_low && !wr_high) |=> !hi_armed_reg)
    else $error("stale high byte kept");

endmodule

`default_nettype wire

// ==== rtl/slr_pkg.sv ====
package slr_pkg;

  // timing base
  localparam int CLK_HZ         = 50_000_000;
  localparam int OSC_HZ         = 128_000;
  localparam int TICK128_CYC    = CLK_HZ / OSC_HZ;
  localparam int WAKE_OSC_TICKS = 4;
  localparam int SYNC_TICKS     = 2;
  localparam int STABLE_TICKS   = 5;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_SLEEP_MODE_CONTROL = 8'h33;
  localparam logic [7:0] IDX_POWER_REDUCTION_0  = 8'h34;
  localparam logic [7:0] IDX_CAL_CONTROL        = 8'h35;
  localparam logic [7:0] IDX_CAL_DATA_LOW       = 8'h36;
  localparam logic [7:0] IDX_CAL_DATA_HIGH      = 8'h37;
  localparam logic [7:0] IDX_PM_STATUS          = 8'h38;

  // sleep_mode_control fields
  localparam int SE_BIT   = 0;
  localparam int MODE_LSB = 1;
  localparam int MODE_MSB = 3;

  // retention_cal_control fields
  localparam int CAL_EN_BIT     = 0;
  localparam int CAL_TCO_BIT    = 1;
  localparam int CAL_SHORT_BIT  = 2;
  localparam int CAL_ACTIVE_BIT = 3;
  localparam int CAL_DONE_BIT   = 4;

  // power_reduction_0 fields
  localparam int GATE_TWO_WIRE_BIT  = 7;
  localparam int GATE_TIMER_2_BIT   = 6;
  localparam int GATE_TIMER_0_BIT   = 5;
  localparam int GAIN_AMP_LOW_BIT   = 4;
  localparam int GATE_TIMER_1_BIT   = 3;
  localparam int GATE_SPI_BIT       = 2;
  localparam int GATE_SERIAL_0_BIT  = 1;

  // reset values
  localparam logic [7:0] SLEEP_CTRL_RST = 8'h00;
  localparam logic [7:0] PWR_RED_RST    = 8'h00;
  localparam logic [2:0] CAL_CTRL_RST   = 3'h1;
  localparam logic [7:0] CAL_DATA_RST   = 8'h00;

  typedef enum logic [2:0] {
    MODE_IDLE      = 3'h0,
    MODE_ADC_NR    = 3'h1,
    MODE_PWR_DOWN  = 3'h2,
    MODE_PWR_SAVE  = 3'h3,
    MODE_RES_4     = 3'h4,
    MODE_RES_5     = 3'h5,
    MODE_STANDBY   = 3'h6,
    MODE_EXT_STBY  = 3'h7
  } sleep_mode_t;

  typedef enum logic [2:0] {
    ST_AWAKE  = 3'b000,
    ST_LIGHT  = 3'b001,
    ST_HOLD   = 3'b010,
    ST_DEEP   = 3'b011,
    ST_WAKEUP = 3'b100
  } pm_state_t;

endpackage

// ==== verif/sleep_and_leakage_regulator_ctrl_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module sleep_and_leakage_regulator_ctrl_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        sleep_i = 1'b0;
  logic        wake = 1'b0;
  logic        cmp = 1'b0;
  logic [31:0] hrdata;
  wire         hready;
  logic        hresp;
  logic        chain;
  logic        act;
  logic        deep;
  logic [2:0]  mode;
  logic [15:0] trim;
  logic        tco;
  logic        sh;
  wire  [6:0]  gates;
  logic [31:0] rd;
  logic [15:0] t0;
  logic [2:0]  modes [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
  int          fail_count = 0;
  int          compares = 0;

  sleep_and_leakage_regulator_ctrl #(.CAL_STEPS(2)) uut (
    .CLOCK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .SLEEP_INSTR_I(sleep_i),
    .WAKE_I(wake), .CAL_COMPARE_I(cmp), .POWER_CHAIN_EN_O(chain), .SLEEP_ACTIVE_O(act),
    .DEEP_SLEEP_O(deep), .SLEEP_MODE_O(mode), .REG_TRIM_O(trim), .TEMP_COEFF_O(tco),
    .REG_SHORT_O(sh), .GATE_TWO_WIRE_O(gates[6]), .GATE_TIMER_2_O(gates[5]),
    .GATE_TIMER_0_O(gates[4]), .GAIN_AMP_LOW_CURRENT_O(gates[3]),
    .GATE_TIMER_1_O(gates[2]), .GATE_SERIAL_PERIPHERAL_O(gates[1]),
    .GATE_SERIAL_PORT_0_O(gates[0])
  );

  always #10 clk = ~clk;

  // comparator flips every cycle, but steps come 780 cycles apart and all see one level
  always @(posedge clk) begin
    cmp <= ~cmp;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude;
    $display("fail_count=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic edge_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      fail_count++;
      conclude();
    end
  endtask

  // one single word transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {2'b00, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    edge_ready();
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    edge_ready();
    rd = hrdata;
  endtask

  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(nm, {24'h0, e}, rd);
  endtask

  task automatic poll(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] v,
                      input int lim);
    int n;
    n = 0;
    do begin
      bus(1'b0, idx, 8'h00);
      n++;
    end while ((rd[7:0] & m) !== v && n < lim);
    chk("poll", {24'h0, v}, {24'h0, rd[7:0] & m});
  endtask

  task automatic pulse;
    sleep_i <= 1'b1;
    @(posedge clk);
    sleep_i <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic wake_up;
    wake <= 1'b1;
    repeat (4) @(posedge clk);
    wake <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk("sleep ctrl", slr_pkg::IDX_SLEEP_MODE_CONTROL, 8'h00);
    bus(1'b0, slr_pkg::IDX_CAL_CONTROL, 8'h00);
    chk("cal enable", 32'h1, {31'h0, rd[0]});
    chk("cal active", 32'h1, {31'h0, rd[3]});
    bus(1'b1, 8'h10, 8'hff);
    rchk("unmapped", 8'h10, 8'h00);
    for (int k = 1; k < 8; k++) begin
      bus(1'b1, slr_pkg::IDX_POWER_REDUCTION_0, 8'h01 << k);
      // the write lands on the edge the task returns at
      @(posedge clk);
      chk("gate bit", 32'h1 << (k - 1), {25'h0, gates});
    end
    bus(1'b1, slr_pkg::IDX_POWER_REDUCTION_0, 8'hff);
    rchk("pwr red", slr_pkg::IDX_POWER_REDUCTION_0, 8'hfe);
    // deep request before any finished cycle must keep the chain up
    bus(1'b1, slr_pkg::IDX_SLEEP_MODE_CONTROL, 8'h05);
    pulse();
    chk("hold", 32'h5, {29'h0, act, deep, chain});
    wake_up();
    chk("hold wake", 32'h1, {29'h0, act, deep, chain});
    bus(1'b1, slr_pkg::IDX_SLEEP_MODE_CONTROL, 8'h04);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, slr_pkg::IDX_SLEEP_MODE_CONTROL, {4'h0, modes[i], 1'b1});
      @(posedge clk);
      chk("mode out", {29'h0, modes[i]}, {29'h0, mode});
      pulse();
      chk("light", {29'h0, modes[i] != 3'h4 && modes[i] != 3'h5, 2'b01},
          {29'h0, act, deep, chain});
      wake_up();
    end
    bus(1'b1, slr_pkg::IDX_SLEEP_MODE_CONTROL, 8'h0c);
    pulse();
    chk("no enable", 32'h1, {29'h0, act, deep, chain});
    poll(slr_pkg::IDX_CAL_CONTROL, 8'h10, 8'h10, 3000);
    bus(1'b1, slr_pkg::IDX_SLEEP_MODE_CONTROL, 8'h07);
    pulse();
    chk("deep", 32'h6, {29'h0, act, deep, chain});
    t0 = trim;
    wake_up();
    repeat (900) @(posedge clk);
    rchk("wakeup wait", slr_pkg::IDX_PM_STATUS, 8'h0c);
    pulse();
    chk("deep again", 32'h6, {29'h0, act, deep, chain});
    chk("old code", {16'h0, t0}, {16'h0, trim});
    wake_up();
    poll(slr_pkg::IDX_PM_STATUS, 8'h07, 8'h00, 1500);
    bus(1'b0, slr_pkg::IDX_CAL_CONTROL, 8'h00);
    chk("done cleared", 32'h0, {31'h0, rd[4]});
    poll(slr_pkg::IDX_CAL_CONTROL, 8'h10, 8'h10, 3000);
    bus(1'b1, slr_pkg::IDX_CAL_CONTROL, 8'h00);
    poll(slr_pkg::IDX_CAL_CONTROL, 8'h09, 8'h00, 1950);
    t0 = trim;
    bus(1'b1, slr_pkg::IDX_CAL_DATA_HIGH, 8'h0f);
    bus(1'b1, slr_pkg::IDX_CAL_DATA_LOW, 8'h06);
    repeat (700) @(posedge clk);
    chk("trim early", {16'h0, t0}, {16'h0, trim});
    poll(slr_pkg::IDX_CAL_CONTROL, 8'h08, 8'h00, 1500);
    chk("trim", 32'h0f06, {16'h0, trim});
    rchk("data low", slr_pkg::IDX_CAL_DATA_LOW, 8'h06);
    rchk("data high", slr_pkg::IDX_CAL_DATA_HIGH, 8'h0f);
    // a write between high and low byte must drop the high byte
    bus(1'b1, slr_pkg::IDX_CAL_DATA_HIGH, 8'haa);
    bus(1'b1, slr_pkg::IDX_POWER_REDUCTION_0, 8'h00);
    bus(1'b1, slr_pkg::IDX_CAL_DATA_LOW, 8'h11);
    poll(slr_pkg::IDX_CAL_CONTROL, 8'h08, 8'h00, 1500);
    chk("dropped high", 32'h0f11, {16'h0, trim});
    bus(1'b1, slr_pkg::IDX_CAL_CONTROL, 8'h07);
    poll(slr_pkg::IDX_CAL_CONTROL, 8'h08, 8'h08, 100);
    bus(1'b1, slr_pkg::IDX_CAL_CONTROL, 8'h01);
    poll(slr_pkg::IDX_CAL_CONTROL, 8'h06, 8'h06, 1500);
    bus(1'b1, slr_pkg::IDX_CAL_DATA_LOW, 8'h55);
    // bits 2:1 only reach the outputs after the crossing, up to two slow ticks
    repeat (2400) @(posedge clk);
    chk("coeff short", 32'h3, {30'h0, tco, sh});
    chk("okay", 32'h0, {31'h0, hresp});
    conclude();
  end
endmodule
`default_nettype wire
